// [verilog/dt_pkg.sv]
// Shared constants and carriers for the DT data-group initiator
package dt_pkg;
  // Bus data width, cycle counter width and owed-transition counter width
  localparam int WORD_W = 16;
  localparam int CNT_W = 8;
  localparam int OWE_W = 8;
  // pCRC generator, seed and pad filler
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam logic [15:0] PAD_WORD = 16'h0000;
  // Tail lengths in words: pad + two pCRC, or two pCRC only
  localparam logic [1:0] TAIL_PAD_LEN = 2'h3;
  localparam logic [1:0] TAIL_NOPAD_LEN = 2'h2;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [OWE_W-1:0] OWE_RST = 8'h00;
  localparam logic [1:0] IDX_RST = 2'h0;
  // Strobe engine states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_HOLD = 3'b100
  } eng_state_type;
  // Pins arriving from the target
  typedef struct packed
  {
    logic req;
    logic pcrca;
    logic io;
    logic [WORD_W-1:0] db;
  } bus_in_type;
  // Pins driven toward the target
  typedef struct packed
  {
    logic ack;
    logic atn;
    logic db_oe;
    logic [WORD_W-1:0] db;
  } bus_out_type;
  localparam bus_out_type BUS_OUT_RST = {1'b0, 1'b0, 1'b0, 16'h0000};
endpackage

// [verilog/dt_initiator.sv]
// Initiator end of DT data-group transfers with pad and pCRC handling
`timescale 1ns/1ps

// Two-entry style elastic buffer, depth and width set by parameters
module dt_buf #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic valid_ff;
  logic ready_ff;
  // Handshakes on each side
  wire push = in_valid & ready_ff;
  wire pop = valid_ff & out_ready;
  wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire [AW-1:0] nxt_wr = (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
  wire [AW-1:0] nxt_rd = (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
  assign in_ready = ready_ff;
  assign out_valid = valid_ff;
  assign out_data = mem_ff[rd_ff];

  // Storage write, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end

  // Pointers and honest full/empty flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      valid_ff <= 1'b0;
      ready_ff <= 1'b1;
    end
    else
    begin
      wr_ff <= push ? nxt_wr : wr_ff;
      rd_ff <= pop ? nxt_rd : rd_ff;
      cnt_ff <= nxt_cnt;
      valid_ff <= (nxt_cnt != '0);
      ready_ff <= (nxt_cnt != FULL);
    end
  end
endmodule

// Initiator controller facing the target's REQ, P_CRCA and data pins
module dt_initiator #(
  parameter int TX_DEPTH = 2,
  parameter int RX_DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bus pins
  input wire dt_pkg::bus_in_type bus_in,
  output dt_pkg::bus_out_type bus_out,
  // Interval settings in core clock cycles, and the narrow lane select
  input wire logic [dt_pkg::CNT_W-1:0] setup_cycles,
  input wire logic [dt_pkg::CNT_W-1:0] assert_cycles,
  input wire logic narrow_mode,
  // Words toward the target
  input wire logic [dt_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Words from the target
  output logic [dt_pkg::WORD_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // Group status
  output logic group_done,
  output logic crc_err,
  input wire logic atn_clr
);
  import dt_pkg::*;

  // Synchroniser stages and edge history
  bus_in_type in_s1_ff;
  bus_in_type in_s2_ff;
  logic req_s3_ff;
  // Strobe engine
  eng_state_type st_ff;
  eng_state_type nxt_st;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  bus_out_type out_ff;
  bus_out_type nxt_out;
  // ACK transitions owed to the target
  logic [OWE_W-1:0] owe_ff;
  logic [OWE_W-1:0] tail_owe_ff;
  logic [OWE_W-1:0] next_owe_ff;
  // Outgoing tail tracking
  logic tail_on_ff;
  logic pad_ff;
  logic [1:0] tail_idx_ff;
  // Incoming tail tracking
  logic rx_tail_ff;
  logic rx_lo_got_ff;
  logic [15:0] rx_lo_ff;
  logic rx_bad_ff;
  // Running pCRC and status
  logic [31:0] crc_ff;
  logic done_ff;
  logic err_ff;
  // Buffer taps
  logic [15:0] txb_data;
  logic txb_valid;
  logic rxb_ready;

  // Bit-serial pCRC step over one 16-bit word, MSB first
  function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [15:0] w);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
      r = (r[31] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction

  // Edge and direction decode on synchronised pins
  wire req_edge = in_s2_ff.req ^ req_s3_ff;
  wire rx_dir = in_s2_ff.io;
  wire pc = in_s2_ff.pcrca;
  // Narrow mode keeps the low lane and discards undefined upper bits
  wire [15:0] rx_word = narrow_mode ? {8'h00, in_s2_ff.db[7:0]} : in_s2_ff.db;

  // Incoming group decode
  wire rx_data_edge = req_edge & rx_dir & ~pc;
  wire rx_tail_edge = req_edge & rx_dir & pc;
  wire rx_pad_edge = rx_tail_edge & ~rx_tail_ff & ~in_s2_ff.req;
  wire rx_hi_edge = rx_tail_edge & ~rx_pad_edge & rx_lo_got_ff;
  wire rx_lo_edge = rx_tail_edge & ~rx_pad_edge & ~rx_lo_got_ff;
  // Data after the tail started, or an overrun, is a malformed group
  wire rx_bad = rx_data_edge & (rx_tail_ff | ~rxb_ready);
  wire rx_mismatch = rx_hi_edge & ({rx_word, rx_lo_ff} != crc_ff);
  wire rx_fail = rx_mismatch | (rx_hi_edge & (rx_bad_ff | rx_bad));

  // Outgoing edge sorting
  wire tx_data_edge = req_edge & ~rx_dir & ~pc;
  wire tx_tail_edge = req_edge & ~rx_dir & pc;
  wire tx_first_tail = tx_tail_edge & ~tail_on_ff;

  // Engine launch choice: owed data first, then the tail
  wire idle = (st_ff == ST_IDLE);
  wire owe_any = (owe_ff != OWE_RST);
  wire take_data = owe_any & (rx_dir ? rxb_ready : txb_valid);
  wire take_tail = ~rx_dir & ~owe_any & (tail_owe_ff != OWE_RST);
  wire start = idle & (take_data | take_tail);
  wire start_tx = start & ~rx_dir;

  // Tail word selection: pad, then low and high pCRC halves
  wire [1:0] tail_len = pad_ff ? TAIL_PAD_LEN : TAIL_NOPAD_LEN;
  wire tail_is_pad = pad_ff & (tail_idx_ff == IDX_RST);
  wire tail_is_lo = (tail_idx_ff == {1'b0, pad_ff});
  wire [15:0] tail_word = tail_is_pad ? PAD_WORD : (tail_is_lo ? crc_ff[15:0] : crc_ff[31:16]);
  wire tail_last = take_tail & (tail_idx_ff == tail_len - 2'h1);
  wire [15:0] tx_lane = narrow_mode ? {8'h00, txb_data[7:0]} : txb_data;
  wire [15:0] load_word = take_data ? tx_lane : tail_word;
  wire tx_crc_upd = start_tx & (take_data | tail_is_pad);
  wire tx_end = start_tx & tail_last;

  // Owed-transition counters, one ACK per REQ transition
  wire [OWE_W-1:0] owe_add = (rx_dir | (tx_data_edge & ~tail_on_ff)) & req_edge ? 8'h01 : 8'h00;
  wire [OWE_W-1:0] owe_dec = (start & take_data) ? 8'h01 : 8'h00;
  wire [OWE_W-1:0] owe_mrg = tx_end ? next_owe_ff : OWE_RST;
  wire [OWE_W-1:0] nxt_owe = owe_ff + owe_add + owe_mrg - owe_dec;
  wire [OWE_W-1:0] nxt_tail_owe = tail_owe_ff + {7'h00, tx_tail_edge} - {7'h00, start & take_tail};
  wire [OWE_W-1:0] nxt_next_owe = tx_end ? {7'h00, tx_data_edge & tail_on_ff}
                                         : next_owe_ff + {7'h00, tx_data_edge & tail_on_ff};

  // Running pCRC update, reseeded at the end of every group
  wire [15:0] crc_in = rx_dir ? rx_word : load_word;
  wire crc_upd = rx_data_edge | rx_pad_edge | tx_crc_upd;
  wire grp_end = rx_hi_edge | tx_end;
  wire [31:0] nxt_crc = grp_end ? CRC_SEED : (crc_upd ? crc_next(crc_ff, crc_in) : crc_ff);
  wire [CNT_W-1:0] cnt_dec = cnt_ff - 8'h01;

  // Input synchronisers; first stage feeds only the second
  // Reset to the idle levels, else an unknown edge history poisons the counters
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
      req_s3_ff <= 1'b0;
    end
    else
    begin
      in_s1_ff <= bus_in;
      in_s2_ff <= in_s1_ff;
      req_s3_ff <= in_s2_ff.req;
    end
  end

  // Strobe engine: setup when sending, toggle, then hold for the assertion period
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    nxt_out.atn = (out_ff.atn & ~atn_clr) | rx_fail | rx_bad;
    case (st_ff)
      ST_IDLE:
      begin
        // Target owns the lines when it sends
        if (rx_dir)
          nxt_out.db_oe = 1'b0;
        if (start & rx_dir)
        begin
          // Receive: answer the REQ edge straight away
          nxt_out.ack = ~out_ff.ack;
          nxt_cnt = assert_cycles;
          nxt_st = ST_HOLD;
        end
        else if (start_tx)
        begin
          // Send: put the word out before the setup wait
          nxt_out.db = load_word;
          nxt_out.db_oe = 1'b1;
          nxt_cnt = setup_cycles;
          nxt_st = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (cnt_ff == CNT_RST)
        begin
          nxt_out.ack = ~out_ff.ack;
          nxt_cnt = assert_cycles;
          nxt_st = ST_HOLD;
        end
        else
          nxt_cnt = cnt_dec;
      end
      ST_HOLD:
      begin
        // Data and ACK stay put for the whole period
        if (cnt_ff == CNT_RST)
          nxt_st = ST_IDLE;
        else
          nxt_cnt = cnt_dec;
      end
      default:
      begin
        nxt_st = ST_IDLE;
        nxt_cnt = CNT_RST;
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= CNT_RST;
      out_ff <= BUS_OUT_RST;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  // Owed counters and outgoing tail state
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      owe_ff <= OWE_RST;
      tail_owe_ff <= OWE_RST;
      next_owe_ff <= OWE_RST;
      tail_on_ff <= 1'b0;
      pad_ff <= 1'b0;
      tail_idx_ff <= IDX_RST;
    end
    else
    begin
      owe_ff <= nxt_owe;
      tail_owe_ff <= nxt_tail_owe;
      next_owe_ff <= nxt_next_owe;
      // REQ level just before the first P_CRCA edge decides the pad;
      // the edge itself has already flipped the synchronised level
      tail_on_ff <= tx_end ? 1'b0 : (tail_on_ff | tx_first_tail);
      pad_ff <= tx_first_tail ? req_s3_ff : pad_ff;
      tail_idx_ff <= tx_end ? IDX_RST : tail_idx_ff + {1'b0, start_tx & take_tail};
    end
  end

  // Incoming tail state and pCRC
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rx_tail_ff <= 1'b0;
      rx_lo_got_ff <= 1'b0;
      rx_lo_ff <= 16'h0000;
      rx_bad_ff <= 1'b0;
      crc_ff <= CRC_SEED;
    end
    else
    begin
      rx_tail_ff <= ~rx_hi_edge & (rx_tail_ff | rx_tail_edge);
      rx_lo_got_ff <= ~rx_hi_edge & (rx_lo_got_ff | rx_lo_edge);
      rx_lo_ff <= rx_lo_edge ? rx_word : rx_lo_ff;
      rx_bad_ff <= ~rx_hi_edge & (rx_bad_ff | rx_bad);
      crc_ff <= nxt_crc;
    end
  end

  // One-cycle group status pulses
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      done_ff <= grp_end;
      err_ff <= rx_fail;
    end
  end

  // Outgoing words wait here; a stall from the user holds the ACK
  dt_buf #(.W(WORD_W), .DEPTH(TX_DEPTH)) u_txbuf (
    .clk(core_clk),
    .rst(sys_rst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(txb_data),
    .out_valid(txb_valid),
    .out_ready(start_tx & take_data)
  );

  // Incoming words; no ACK while it is full, so the offset paces the target
  dt_buf #(.W(WORD_W), .DEPTH(RX_DEPTH)) u_rxbuf (
    .clk(core_clk),
    .rst(sys_rst),
    .in_data(rx_word),
    .in_valid(rx_data_edge),
    .in_ready(rxb_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign bus_out = out_ff;
  assign group_done = done_ff;
  assign crc_err = err_ff;
endmodule

// [verification/dt_checker.sv]
// Port-level concurrent checks for the DT data-group initiator
`timescale 1ns/1ps
module dt_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins toward the target
  input wire dt_pkg::bus_out_type bus_out,
  // Interval and lane settings
  input wire logic [dt_pkg::CNT_W-1:0] setup_cycles,
  input wire logic [dt_pkg::CNT_W-1:0] assert_cycles,
  input wire logic narrow_mode,
  // Receive stream and status
  input wire logic [dt_pkg::WORD_W-1:0] rx_data,
  input wire logic rx_valid,
  input wire logic group_done,
  input wire logic crc_err,
  input wire logic atn_clr
);
  import dt_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic ack_q_ff; // ACK one cycle back
  logic [15:0] db_q_ff; // Data one cycle back
  logic [7:0] ack_age_ff; // Cycles since ACK last moved
  logic [7:0] db_age_ff; // Cycles since data last moved
  // Change detects and saturating ages; reset age is high so the first edge passes
  wire ack_flip = bus_out.ack != ack_q_ff;
  wire db_flip = bus_out.db != db_q_ff;
  wire [7:0] nxt_ack_age = ack_flip ? 8'h01 : ack_age_ff + {7'h00, ack_age_ff != 8'hFF};
  wire [7:0] nxt_db_age = db_flip ? 8'h01 : db_age_ff + {7'h00, db_age_ff != 8'hFF};
  // Age tracking registers
  always_ff @(posedge core_clk)
  begin
    ack_q_ff <= bus_out.ack;
    db_q_ff <= bus_out.db;
    ack_age_ff <= sys_rst ? 8'hFF : nxt_ack_age;
    db_age_ff <= sys_rst ? 8'hFF : nxt_db_age;
  end
  property p_ack_hold;
    ack_flip |-> ack_age_ff > assert_cycles;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack moved too early");
  property p_setup;
    bus_out.db_oe && ack_flip |-> db_age_ff > setup_cycles;
  endproperty
  a_setup: assert property (p_setup) else $error("ack before data setup");
  property p_db_hold;
    bus_out.db_oe && db_flip |-> ack_age_ff > assert_cycles;
  endproperty
  a_db_hold: assert property (p_db_hold) else $error("data changed in hold");
  property p_err_done;
    crc_err |-> group_done;
  endproperty
  a_err_done: assert property (p_err_done) else $error("error without group end");
  property p_err_atn;
    crc_err |-> bus_out.atn;
  endproperty
  a_err_atn: assert property (p_err_atn) else $error("error without attention");
  property p_atn_rise;
    $rose(bus_out.atn) |-> crc_err;
  endproperty
  a_atn_rise: assert property (p_atn_rise) else $error("attention without error");
  property p_atn_clr;
    atn_clr |=> !bus_out.atn || crc_err;
  endproperty
  a_atn_clr: assert property (p_atn_clr) else $error("attention not cleared");
  property p_done_pulse;
    group_done |=> !group_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("group end too long");
  property p_narrow;
    narrow_mode && rx_valid |-> rx_data[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper lane not ignored");
endmodule

bind dt_initiator dt_checker dt_checker_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .bus_out(bus_out), .setup_cycles(setup_cycles), .assert_cycles(assert_cycles),
  .narrow_mode(narrow_mode), .rx_data(rx_data), .rx_valid(rx_valid),
  .group_done(group_done), .crc_err(crc_err), .atn_clr(atn_clr));

// [verification/dt_target.sv]
// Behavioural target end of the DT link, offset of one transition
`timescale 1ns/1ps
module dt_target (
  // From the initiator
  input wire logic ack,
  input wire logic [15:0] db_in,
  // Toward the initiator
  output logic req,
  output logic pcrca,
  output logic io,
  output logic [15:0] db_out
);
  import dt_pkg::*;
  logic [15:0] got[$]; // Words taken on ACK edges
  initial
  begin
    req = 1'h0;
    pcrca = 1'h0;
    io = 1'h1;
    db_out = 16'h5A5A;
  end
  // One group: data words, then pad if REQ ends high, then two pCRC words
  task automatic run(input logic dir, input logic [15:0] wq[$], input logic [31:0] crc);
    int n;
    int k;
    logic [15:0] w;
    n = wq.size();
    k = (n % 2) ? 0 : 1;
    io = dir;
    got.delete();
    for (int i = 0; i < n + 3 - k; i++)
    begin
      w = (i < n) ? wq[i] : (i - n + k == 0) ? PAD_WORD : (i - n + k == 1) ? crc[15:0] : crc[31:16];
      db_out = dir ? w : ~db_out;
      pcrca = (i >= n);
      #400;
      req = ~req;
      @(ack);
      if (!dir) got.push_back(db_in);
    end
    #400;
    pcrca = 1'h0;
  endtask
endmodule

// [verification/dt_data_group_pcrc_transfer_tb.sv]
// Self-checking bench for the DT data-group initiator
`timescale 1ns/1ps
module dt_data_group_pcrc_transfer_tb;
  import dt_pkg::*;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  bus_in_type bus_in;
  bus_out_type bus_out;
  logic [CNT_W-1:0] setup_cycles = 8'h02;
  logic [CNT_W-1:0] assert_cycles = 8'h01;
  logic narrow_mode = 1'h0;
  logic [WORD_W-1:0] tx_data = 16'h0000;
  logic tx_valid = 1'h0;
  logic tx_ready;
  logic [WORD_W-1:0] rx_data;
  logic rx_valid;
  logic rx_ready = 1'h1;
  logic group_done;
  logic crc_err;
  logic atn_clr = 1'h0;
  logic t_req; // Target pins before the data wire is resolved
  logic t_pcrca;
  logic t_io;
  logic [15:0] t_db;
  logic [15:0] rx_got[$];
  int failures = 0;
  int cmp_count = 0;
  int done_n = 0;
  int err_n = 0;
  int cyc = 0;
  // Initiator owns the data wire while its enable is high
  assign bus_in = {t_req, t_pcrca, t_io, bus_out.db_oe ? bus_out.db : t_db};
  dt_initiator dt_initiator_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus_in(bus_in),
    .bus_out(bus_out), .setup_cycles(setup_cycles), .assert_cycles(assert_cycles),
    .narrow_mode(narrow_mode), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .group_done(group_done),
    .crc_err(crc_err), .atn_clr(atn_clr));
  dt_target dt_target_i (.ack(bus_out.ack), .db_in(bus_in.db), .req(t_req), .pcrca(t_pcrca),
    .io(t_io), .db_out(t_db));
  always #50 core_clk = ~core_clk;
  // Pulse counters and hang guard; falling edge so pulses are settled
  always @(negedge core_clk)
  begin
    cyc++;
    if (!sys_rst && group_done === 1'h1) done_n++;
    if (!sys_rst && crc_err === 1'h1) err_n++;
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // MSB-first CRC over one 16-bit word
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [15:0] w);
    logic [31:0] r;
    r = c;
    for (int b = 15; b >= 0; b--)
      r = (r[31] ^ w[b]) ? {r[30:0], 1'h0} ^ CRC_POLY : {r[30:0], 1'h0};
    return r;
  endfunction
  // Receiver stalls first so the buffer fills and ACKs stop
  task automatic pull(input int n);
    rx_ready = 1'h0;
    repeat (40) @(negedge core_clk);
    rx_ready = 1'h1;
    while (rx_got.size() < n)
    begin
      if (rx_valid === 1'h1) rx_got.push_back(rx_data);
      @(negedge core_clk);
    end
  endtask
  // Receive group; bad flips a pCRC bit, nar uses the low lane only
  task automatic t_rx(input int n, input logic bad, input logic nar);
    logic [15:0] wq[$];
    logic [31:0] c;
    int d0;
    int e0;
    c = CRC_SEED;
    d0 = done_n;
    e0 = err_n;
    narrow_mode = nar;
    rx_got.delete();
    for (int i = 0; i < n; i++)
    begin
      wq.push_back(16'hC3A5 + 16'h1357 * 16'(i));
      c = crc_step(c, wq[i]);
    end
    if (n % 2) c = crc_step(c, PAD_WORD);
    fork
      dt_target_i.run(1'h1, wq, c ^ {31'h0, bad});
      pull(n);
    join
    repeat (8) @(negedge core_clk);
    foreach (wq[i]) check(32'(rx_got[i]), 32'(nar ? {8'h00, wq[i][7:0]} : wq[i]));
    check(32'(done_n - d0), 32'h1);
    if (!nar) check(32'(err_n - e0), 32'(bad));
    if (!nar) check(32'(bus_out.atn), 32'(bad));
    narrow_mode = 1'h0;
  endtask
  // Attention release
  task automatic t_clr();
    atn_clr = 1'h1;
    @(negedge core_clk);
    atn_clr = 1'h0;
    @(negedge core_clk);
    check(32'(bus_out.atn), 32'h0);
  endtask
  // Send group; odd count forces the pad word
  task automatic t_tx(input int n);
    logic [15:0] wq[$];
    logic [15:0] ex[$];
    logic [31:0] c;
    int d0;
    c = CRC_SEED;
    d0 = done_n;
    for (int i = 0; i < n; i++)
    begin
      wq.push_back(16'h8E21 ^ (16'h0F0F * 16'(i)));
      c = crc_step(c, wq[i]);
    end
    ex = wq;
    if (n % 2)
    begin
      ex.push_back(PAD_WORD);
      c = crc_step(c, PAD_WORD);
    end
    ex.push_back(c[15:0]);
    ex.push_back(c[31:16]);
    fork
      dt_target_i.run(1'h0, wq, 32'h0);
      begin
        foreach (wq[i])
        begin
          tx_data = wq[i];
          tx_valid = 1'h1;
          while (tx_ready !== 1'h1) @(negedge core_clk);
          @(negedge core_clk);
        end
        tx_valid = 1'h0;
      end
    join
    repeat (8) @(negedge core_clk);
    check(32'(dt_target_i.got.size()), 32'(ex.size()));
    foreach (ex[i]) check(32'(dt_target_i.got[i]), 32'(ex[i]));
    check(32'(done_n - d0), 32'h1);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'h0;
    repeat (4) @(negedge core_clk);
    t_rx(3, 1'h0, 1'h0);
    t_rx(4, 1'h0, 1'h0);
    t_rx(2, 1'h1, 1'h0);
    t_clr();
    t_rx(3, 1'h0, 1'h1);
    t_clr();
    t_tx(3);
    t_tx(2);
    close_out();
  end
endmodule
